// ===== rtl/pbs_defines.svh
// Constants for the bridge state control block
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

// Clock and toggle-loss timing
`define PBS_CLK_PERIOD_NS     50
`define PBS_TOGGLE_TIMEOUT_NS 10000
`define PBS_TOGGLE_CYCLES     (`PBS_TOGGLE_TIMEOUT_NS / `PBS_CLK_PERIOD_NS)
`define PBS_CNT_W             9

// Synchroniser width and bit positions of the pin vector
`define PBS_SYNC_W  10
`define PBS_IN_PDN  0
`define PBS_IN_RST  1
`define PBS_IN_AP   2
`define PBS_IN_AM   3
`define PBS_IN_BP   4
`define PBS_IN_BM   5
`define PBS_IN_OVC  6
`define PBS_IN_OVT  7
`define PBS_IN_LOWV 8
`define PBS_IN_WARN 9
`define PBS_SYNC_RESET 10'h000

// Status codes {shutdown, code1, code0}
`define PBS_CODE_W       3
`define PBS_CODE_ILLEGAL 3'h0
`define PBS_CODE_OVC     3'h1
`define PBS_CODE_OVT     3'h2
`define PBS_CODE_LOWV    3'h3
`define PBS_CODE_WARN    3'h6
`define PBS_CODE_NORMAL  3'h7
`define PBS_CODE_SD      2
`define PBS_CODE_B1      1
`define PBS_CODE_B0      0

`endif

// ===== rtl/pbs_pkg.sv
// Types and shared decode for the bridge state control block
`default_nettype none
package pbs_pkg;

  // Output mode, Gray coded along power-down, reset, run, faults
  typedef enum logic [2:0]
  {
    PBS_PWRDN     = 3'h0,
    PBS_RESET     = 3'h1,
    PBS_RUN       = 3'h3,
    PBS_FAULT_LOW = 3'h2,
    PBS_FAULT_HIZ = 3'h6
  } pbs_mode_e;

  // Equal plus and minus levels are not a valid complementary pair
  function automatic logic pbs_illegal(input logic plus, input logic minus);
  begin
    pbs_illegal = (plus == minus);
  end
  endfunction

endpackage
`default_nettype wire

// ===== rtl/pbs_toggle_watch.sv
// Loss-of-toggle detector for one PWM input
`default_nettype none
module pbs_toggle_watch
  import pbs_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Watched level, already synchronised, and hold-off
  input  wire logic level,
  input  wire logic clear,
  // Toggle lost
  output var  logic lost
);

  `include "pbs_defines.svh"

  localparam logic [`PBS_CNT_W-1:0] Timeout =
    `PBS_CNT_W'(`PBS_TOGGLE_CYCLES);

  logic                  lastLevel;
  logic [`PBS_CNT_W-1:0] idleCnt;
  logic                  next_lastLevel;
  logic [`PBS_CNT_W-1:0] next_idleCnt;
  logic                  next_lost;

  // Count cycles since the last edge, saturating at the timeout
  always_comb
  begin
    next_lastLevel = level;
    next_idleCnt   = idleCnt;
    next_lost      = lost;
    if (clear || (level != lastLevel))
    begin
      next_idleCnt = '0;
      next_lost    = 1'b0;
    end
    else if (idleCnt >= Timeout)
    begin
      next_lost = 1'b1;
    end
    else
    begin
      next_idleCnt = idleCnt + `PBS_CNT_W'(1);
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lastLevel <= 1'b0;
      idleCnt   <= '0;
      lost      <= 1'b0;
    end
    else
    begin
      lastLevel <= next_lastLevel;
      idleCnt   <= next_idleCnt;
      lost      <= next_lost;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/pbs_bridge_ctrl.sv
// H-bridge state control: decode, overrides, fault shutdown, status
// Functional notes
// - Power-down low puts bridge outputs high impedance, status released high.
// - Reset low ignores PWM, drives both bridge outputs low, status high.
// - Reset low clears every recorded fault; the short latch clears only while over-current is absent.
// - Normal mode: plus 1 minus 0 drives high, plus 0 minus 1 low.
// - Equal plus and minus is illegal: output low, status low.
// - Any fault shuts the bridge at once and pulls status low.
// - Over-current gives high impedance; other faults drive outputs low.
// - Status is open drain: released for normal, driven low in fault.
// - Side B uses identical decoding, overrides and fault mapping.
// - Over-current latches until reset; other faults recover on their own.
// - Loss of PWM toggling is treated as an illegal input.
// - Status and two code bits encode each condition per code table.
`default_nettype none
module pbs_bridge_ctrl
  import pbs_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control pins
  input  wire logic power_down_n,
  input  wire logic mute_reset_n,
  // PWM pairs from the modulator
  input  wire logic side_a_plus_in,
  input  wire logic side_a_minus_in,
  input  wire logic side_b_plus_in,
  input  wire logic side_b_minus_in,
  // Analog sense results
  input  wire logic overCurrent,
  input  wire logic overTemp,
  input  wire logic lowVoltage,
  input  wire logic tempWarning,
  // Bridge drive, level and enable per side
  output var  logic bridge_a_out,
  output var  logic bridge_a_oe,
  output var  logic bridge_b_out,
  output var  logic bridge_b_oe,
  // Open-drain status, enable high pulls the pin low
  output var  logic shutdownNOe,
  output var  logic fault_code_bit1_n_oe,
  output var  logic fault_code_bit0_n_oe
);

  `include "pbs_defines.svh"

  logic [`PBS_SYNC_W-1:0] pinMeta;
  logic [`PBS_SYNC_W-1:0] pinSync;
  logic [`PBS_SYNC_W-1:0] pinRaw;

  logic                   ovcLatch;
  logic                   next_ovcLatch;

  pbs_mode_e              mode;
  logic [`PBS_CODE_W-1:0] code;

  logic                   next_bridgeAOut;
  logic                   next_bridgeAOe;
  logic                   next_bridgeBOut;
  logic                   next_bridgeBOe;
  logic                   next_shutdownNOe;
  logic                   next_code1Oe;
  logic                   next_code0Oe;

  logic                   pwrDown;
  logic                   inReset;
  logic                   ovcNow;
  logic                   lostA;
  logic                   lostB;
  logic                   illegalA;
  logic                   illegalB;
  logic                   illegalAny;
  logic                   watchClear;

  // Gather the pins so one synchroniser covers them all
  assign pinRaw = {tempWarning, lowVoltage, overTemp, overCurrent,
                   side_b_minus_in, side_b_plus_in,
                   side_a_minus_in, side_a_plus_in,
                   mute_reset_n, power_down_n};

  // Two-flop synchroniser; only the second stage is read
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinMeta <= `PBS_SYNC_RESET;
      pinSync <= `PBS_SYNC_RESET;
    end
    else
    begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  // Override levels taken from the synchronised pins
  assign pwrDown    = ~pinSync[`PBS_IN_PDN];
  assign inReset    = ~pinSync[`PBS_IN_RST];
  assign ovcNow     = pinSync[`PBS_IN_OVC];
  // Watchers restart while power-down or reset holds the bridge
  assign watchClear = pwrDown | inReset;

  // Loss of toggling watched on the plus input of each side
  pbs_toggle_watch uWatchA
  (
    .clk   (clk),
    .rst_b (rst_b),
    .level (pinSync[`PBS_IN_AP]),
    .clear (watchClear),
    .lost  (lostA)
  );

  pbs_toggle_watch uWatchB
  (
    .clk   (clk),
    .rst_b (rst_b),
    .level (pinSync[`PBS_IN_BP]),
    .clear (watchClear),
    .lost  (lostB)
  );

  // Illegal pair or stalled input, per side
  assign illegalA = pbs_illegal(pinSync[`PBS_IN_AP],
                                pinSync[`PBS_IN_AM]) | lostA;
  assign illegalB = pbs_illegal(pinSync[`PBS_IN_BP],
                                pinSync[`PBS_IN_BM]) | lostB;
  // One bad side shuts the whole bridge, both halves go low together
  assign illegalAny = illegalA | illegalB;

  // Short-circuit latch; a new event beats a clear in the same cycle
  always_comb
  begin
    next_ovcLatch = ovcLatch;
    if (ovcNow)
    begin
      next_ovcLatch = 1'b1;
    end
    else if (inReset)
    begin
      next_ovcLatch = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ovcLatch <= 1'b0;
    end
    else
    begin
      ovcLatch <= next_ovcLatch;
    end
  end

  // Mode selection; power-down outranks reset, reset outranks faults
  always_comb
  begin
    if (pwrDown)
    begin
      mode = PBS_PWRDN;
    end
    else if (inReset)
    begin
      mode = PBS_RESET;
    end
    else if (ovcLatch || ovcNow)
    begin
      mode = PBS_FAULT_HIZ;
    end
    else if (pinSync[`PBS_IN_LOWV] || pinSync[`PBS_IN_OVT] || illegalAny)
    begin
      mode = PBS_FAULT_LOW;
    end
    else
    begin
      mode = PBS_RUN;
    end
  end

  // Status code; released pins read high during power-down and reset
  always_comb
  begin
    case (mode)
      PBS_PWRDN:     code = `PBS_CODE_NORMAL;
      PBS_RESET:     code = `PBS_CODE_NORMAL;
      PBS_FAULT_HIZ: code = `PBS_CODE_OVC;
      PBS_FAULT_LOW:
      begin
        // Supply problems are reported ahead of temperature and input
        if (pinSync[`PBS_IN_LOWV])
        begin
          code = `PBS_CODE_LOWV;
        end
        else if (pinSync[`PBS_IN_OVT])
        begin
          code = `PBS_CODE_OVT;
        end
        else
        begin
          code = `PBS_CODE_ILLEGAL;
        end
      end
      PBS_RUN:
      begin
        // Warning keeps the bridge running, only the code changes
        code = pinSync[`PBS_IN_WARN] ? `PBS_CODE_WARN
                                     : `PBS_CODE_NORMAL;
      end
      default:       code = `PBS_CODE_ILLEGAL;
    endcase
  end

  // Next output values; both sides share the same mapping
  always_comb
  begin
    next_bridgeAOut = 1'b0;
    next_bridgeBOut = 1'b0;
    next_bridgeAOe  = 1'b1;
    next_bridgeBOe  = 1'b1;
    case (mode)
      PBS_PWRDN, PBS_FAULT_HIZ:
      begin
        next_bridgeAOe = 1'b0;
        next_bridgeBOe = 1'b0;
      end
      PBS_RUN:
      begin
        next_bridgeAOut = pinSync[`PBS_IN_AP];
        next_bridgeBOut = pinSync[`PBS_IN_BP];
      end
      default:
      begin
        // Reset and low-low fault keep both outputs driven low
        next_bridgeAOut = 1'b0;
        next_bridgeBOut = 1'b0;
      end
    endcase
    // Open drain: enable high pulls a zero bit onto the pin
    next_shutdownNOe = ~code[`PBS_CODE_SD];
    next_code1Oe     = ~code[`PBS_CODE_B1];
    next_code0Oe     = ~code[`PBS_CODE_B0];
  end

  // Output registers; reset value is the powered-down safe state
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bridge_a_out         <= 1'b0;
      bridge_a_oe          <= 1'b0;
      bridge_b_out         <= 1'b0;
      bridge_b_oe          <= 1'b0;
      shutdownNOe          <= 1'b0;
      fault_code_bit1_n_oe <= 1'b0;
      fault_code_bit0_n_oe <= 1'b0;
    end
    else
    begin
      bridge_a_out         <= next_bridgeAOut;
      bridge_a_oe          <= next_bridgeAOe;
      bridge_b_out         <= next_bridgeBOut;
      bridge_b_oe          <= next_bridgeBOe;
      shutdownNOe          <= next_shutdownNOe;
      fault_code_bit1_n_oe <= next_code1Oe;
      fault_code_bit0_n_oe <= next_code0Oe;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/pbs_mod_model.sv
// Behavioural PWM modulator driving both complementary pairs
`default_nettype none
module pbs_mod_model
(
  // Clock and control from the bench
  input  wire logic clk,
  input  wire logic run,
  input  wire logic badA,
  input  wire logic badB,
  // PWM pairs
  output var  logic aP,
  output var  logic aM,
  output var  logic bP,
  output var  logic bM
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph = 1'b0;
  // Phase flips each cycle; stopping it models a lost PWM clock
  always @(posedge clk)
  begin
    if (run)
      ph <= ~ph;
  end
  // Pairs stay complementary unless told to break
  assign aP = ph;
  assign aM = badA ? ph : ~ph;
  assign bP = ~ph;
  assign bM = badB ? ~ph : ph;
endmodule
`default_nettype wire

// ===== testbench/pbs_bridge_ctrl_asserts.sv
// Concurrent checks on the bridge state control ports
`default_nettype none
module pbs_bridge_ctrl_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pins into the block
  input wire logic power_down_n,
  input wire logic mute_reset_n,
  input wire logic side_a_plus_in,
  input wire logic side_a_minus_in,
  input wire logic side_b_plus_in,
  input wire logic side_b_minus_in,
  input wire logic overCurrent,
  input wire logic overTemp,
  input wire logic lowVoltage,
  input wire logic tempWarning,
  // Outputs of the block
  input wire logic bridge_a_out,
  input wire logic bridge_a_oe,
  input wire logic bridge_b_out,
  input wire logic bridge_b_oe,
  input wire logic shutdownNOe,
  input wire logic fault_code_bit1_n_oe,
  input wire logic fault_code_bit0_n_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] d1, d2, d3, next_d1, next_d2, next_d3;
  logic [7:0] stuck, next_stuck;
  wire  [6:0] o = {bridge_a_oe, bridge_a_out, bridge_b_oe, bridge_b_out,
                   shutdownNOe, fault_code_bit1_n_oe, fault_code_bit0_n_oe};
  wire        run = d3[7] && d3[0] && d3[1];
  // Pins delayed three edges, like the path to the outputs
  always_comb
  begin
    next_d1 = {1'b1, lowVoltage, overCurrent, side_b_plus_in,
               side_a_minus_in, side_a_plus_in, mute_reset_n, power_down_n};
    next_d2 = d1;
    next_d3 = d2;
    next_stuck = stuck + {7'h00, stuck != 8'hff};
    if (!power_down_n || !mute_reset_n || side_a_plus_in != d1[2])
      next_stuck = 8'h00;
  end
  // Cleared by reset so nothing is judged on stale pins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      d1    <= 8'h00;
      d2    <= 8'h00;
      d3    <= 8'h00;
      stuck <= 8'h00;
    end
    else
    begin
      d1    <= next_d1;
      d2    <= next_d2;
      d3    <= next_d3;
      stuck <= next_stuck;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_powerdown_hiz:
    assert property (d3[7] && !d3[0] |-> (o & 7'h57) == 7'h00)
    else $error("drive seen in power-down");
  a_reset_low:
    assert property (d3[7] && d3[0] && !d3[1] |-> o == 7'h50)
    else $error("reset state wrong");
  a_illegal_low:
    assert property (run && d3[2] == d3[3] |-> o[2] && !(o[6] && o[5]))
    else $error("illegal pair not shut");
  a_run_follow:
    assert property (run && !o[2] |-> o[6:3] == {1'b1, d3[2], 1'b1, d3[4]})
    else $error("bridge not following plus input");
  a_ovc_hiz:
    assert property (run && d3[5] |-> (o & 7'h57) == 7'h06)
    else $error("over-current state wrong");
  a_ovc_latch:
    assert property (run && d2[0] && d2[1] && o[2] && !o[6] |=> o[2] && !o[6])
    else $error("over-current latch dropped");
  a_lowv_code:
    assert property (run && d3[6] && !d3[5] && o[6] |-> o == 7'h54)
    else $error("low voltage code wrong");
  a_lost_shut:
    assert property (stuck == 8'hff |-> o[2])
    else $error("toggle loss not shut");
  c_ovc: cover property (run && d3[5]);
  c_lowv: cover property (run && d3[6]);
  c_lost: cover property (stuck == 8'hff);
endmodule
bind pbs_bridge_ctrl pbs_bridge_ctrl_asserts u_chk (.*);
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the bridge state control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk          = 1'b0;
  logic       rst_b        = 1'b0;
  logic       power_down_n = 1'b0;
  logic       mute_reset_n = 1'b0;
  logic       overCurrent  = 1'b0;
  logic       overTemp     = 1'b0;
  logic       lowVoltage   = 1'b0;
  logic       tempWarning  = 1'b0;
  logic       run          = 1'b0;
  logic       badA         = 1'b0;
  logic       badB         = 1'b0;
  wire        aP, aM, bP, bM;
  wire  [6:0] outs;
  int         badCount     = 0;
  int         totalChecks  = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  pbs_mod_model u_mod (.clk(clk), .run(run), .badA(badA), .badB(badB),
                       .aP(aP), .aM(aM), .bP(bP), .bM(bM));
  pbs_bridge_ctrl u_dut (.clk(clk), .rst_b(rst_b),
    .power_down_n(power_down_n), .mute_reset_n(mute_reset_n),
    .side_a_plus_in(aP), .side_a_minus_in(aM), .side_b_plus_in(bP),
    .side_b_minus_in(bM), .overCurrent(overCurrent), .overTemp(overTemp),
    .lowVoltage(lowVoltage), .tempWarning(tempWarning),
    .bridge_a_oe(outs[6]), .bridge_a_out(outs[5]), .bridge_b_oe(outs[4]),
    .bridge_b_out(outs[3]), .shutdownNOe(outs[2]),
    .fault_code_bit1_n_oe(outs[1]), .fault_code_bit0_n_oe(outs[0]));
  // Inputs always move the same 5 ns after an edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  // Masked compare; a masked-in unknown still fails
  task automatic chk(input string nm, input logic [6:0] e,
                     input logic [6:0] m);
    totalChecks++;
    if (((outs ^ e) & m) !== 7'h00)
    begin
      badCount++;
      $display("unexpected %s exp %h got %h", nm, e, outs);
    end
  endtask
  // Normal decode from the held model levels
  function automatic logic [6:0] norm();
    return {1'b1, aP, 1'b1, bP, 3'h0};
  endfunction
  // One phase flip rearms the toggle watch, then outputs settle
  task automatic kick();
    run = 1'b1;
    step(1);
    run = 1'b0;
    step(4);
  endtask
  task automatic t_powerdown();
    step(4);
    chk("pdn with reset", 7'h00, 7'h57);
    mute_reset_n = 1'b1;
    step(4);
    chk("pdn", 7'h00, 7'h57);
    power_down_n = 1'b1;
    $display("done powerdown");
  endtask
  task automatic t_run();
    kick();
    chk("run phase 1", norm(), 7'h7f);
    kick();
    chk("run phase 2", norm(), 7'h7f);
    $display("done run");
  endtask
  task automatic t_illegal();
    kick();
    badA = 1'b1;
    step(4);
    chk("illegal a", 7'h57, 7'h7f);
    badA = 1'b0;
    step(4);
    chk("recover a", norm(), 7'h7f);
    badB = 1'b1;
    step(4);
    chk("illegal b", 7'h57, 7'h7f);
    badB = 1'b0;
    $display("done illegal");
  endtask
  task automatic t_sense();
    logic [6:0] e [3];
    kick();
    e = '{7'h54, 7'h55, norm() | 7'h01};
    for (int i = 0; i < 3; i++)
    begin
      {tempWarning, overTemp, lowVoltage} = 3'h1 << i;
      step(4);
      chk("sense code", e[i], 7'h7f);
      {tempWarning, overTemp, lowVoltage} = 3'h0;
      step(4);
      chk("sense clear", norm(), 7'h7f);
    end
    $display("done sense");
  endtask
  task automatic t_ovc();
    kick();
    overCurrent = 1'b1;
    step(1);
    overCurrent = 1'b0;
    step(1);
    chk("ovc not yet seen", norm(), 7'h7f);
    step(2);
    chk("ovc", 7'h06, 7'h57);
    step(20);
    chk("ovc held", 7'h06, 7'h57);
    mute_reset_n = 1'b0;
    step(4);
    chk("reset low", 7'h50, 7'h7f);
    mute_reset_n = 1'b1;
    kick();
    chk("after reset", norm(), 7'h7f);
    $display("done ovc");
  endtask
  task automatic t_lost();
    kick();
    step(260);
    chk("toggle lost", 7'h57, 7'h7f);
    kick();
    chk("toggle back", norm(), 7'h7f);
    $display("done lost");
  endtask
  // Single exit with the verdict
  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    step(6);
    chk("in reset", 7'h00, 7'h7f);
    rst_b = 1'b1;
    t_powerdown();
    t_run();
    t_illegal();
    t_sense();
    t_ovc();
    t_lost();
    finishTest();
  end
endmodule
`default_nettype wire
